// >>> hdl/grip_cmd_pkg.sv
package grip_cmd_pkg;

    // ****************************************
    // Command image byte offsets
    // ****************************************
    localparam logic [3:0] OFS_ACTION = 4'h0;
    localparam logic [3:0] OFS_OPT_ONE = 4'h1;
    localparam logic [3:0] OFS_OPT_TWO = 4'h2;
    localparam logic [3:0] OFS_TARGET = 4'h3;
    localparam logic [3:0] OFS_SPEED = 4'h4;
    localparam logic [3:0] OFS_FORCE = 4'h5;

    // ****************************************
    // Status image byte offsets
    // ****************************************
    localparam logic [3:0] OFS_GRIP_STAT = 4'h0;
    localparam logic [3:0] OFS_FAULT = 4'h2;
    localparam logic [3:0] OFS_POS_ECHO = 4'h3;
    localparam logic [3:0] OFS_POSITION = 4'h4;

    // ****************************************
    // Action byte fields
    // ****************************************
    localparam int BIT_ACT = 0;
    localparam int BIT_GOTO = 3;
    localparam int BIT_ATR = 4;
    localparam int BIT_DIR = 5;

    // ****************************************
    // Status byte 0 fields
    // ****************************************
    localparam int BIT_ACT_ECHO = 0;
    localparam int BIT_GOTO_ECHO = 3;
    localparam int LSB_MOTION = 4;
    localparam int LSB_OBJECT = 6;

    // ****************************************
    // Fault codes and reset values
    // ****************************************
    localparam logic [3:0] FLT_NONE = 4'h0;
    localparam logic [3:0] FLT_NO_ACT = 4'h7;
    localparam logic [3:0] FLT_REL_BUSY = 4'hB;
    localparam logic [3:0] FLT_REL_DONE = 4'hF;
    localparam logic [7:0] RST_BYTE = 8'h00;

    // ****************************************
    // Motion and object codes
    // ****************************************
    localparam logic [1:0] MOT_RESET = 2'h0;
    localparam logic [1:0] MOT_CALIB = 2'h1;
    localparam logic [1:0] MOT_READY = 2'h3;
    localparam logic [1:0] OBJ_MOVING = 2'h0;
    localparam logic [1:0] OBJ_OPENING = 2'h1;
    localparam logic [1:0] OBJ_CLOSING = 2'h2;
    localparam logic [1:0] OBJ_AT_POS = 2'h3;

    // Encoder counts with force limit ignored
    localparam logic [7:0] BLANK_DIST = 8'h08;

endpackage

// >>> hdl/grip_sync.sv
`timescale 1ns/10ps

module grip_sync #(
    parameter int W = 1
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_r;

    // ****************************************
    // Two-stage synchroniser
    // ****************************************
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            meta_r <= '0;
            q <= '0;
        end
        else
        begin
            meta_r <= d;
            q <= meta_r;
        end
    end

endmodule // grip_sync

// >>> hdl/grip_cmd.sv
// Operation
// - Multi-byte values stored least significant byte first
// - Both images indexed from byte zero
// - Activate starts init; clearing resets, clears fault
// - Rising activate starts calibration against stops
// - Goto moves to target; clear stops
// - No motion without goto except calibration/release
// - Release runs to limits, then faults, locks
// - Release overrides all commands except activate
// - Release direction sampled when release starts
// - Target byte stores position, never starts motion
// - Speed applied live, never starts motion
// - Force limits current; overrun stops, flags object
// - Force limit ignored briefly after motion start
// - Target position echoed in status byte
// - Status echoes activate bit, and goto bit only while in move
// - Motion request without activate reports code 07
// - Completed release reports code 0F until reset
`timescale 1ns/10ps

module grip_cmd (
    input wire logic REF_CLK,
    input wire logic RESET,
    input wire logic WR_EN,
    input wire logic [3:0] WR_ADDR,
    input wire logic [7:0] WR_DATA,
    input wire logic [3:0] RD_ADDR,
    output logic [7:0] RD_DATA,
    input wire logic CAL_DONE,
    input wire logic LIMIT_REACHED,
    input wire logic AT_TARGET,
    input wire logic OVER_CURRENT,
    input wire logic [7:0] FINGER_POS,
    output logic CALIBRATE,
    output logic MOTOR_RUN,
    output logic MOTOR_CLOSE,
    output logic [7:0] MOTOR_TARGET,
    output logic [7:0] MOTOR_SPEED,
    output logic [7:0] CURRENT_LIMIT,
    output logic CURRENT_LIMIT_EN
);

    typedef enum logic [5:0] {
        ST_RESET = 6'h01,
        ST_CALIB = 6'h02,
        ST_IDLE = 6'h04,
        ST_MOVE = 6'h08,
        ST_RELEASE = 6'h10,
        ST_LOCKED = 6'h20
    } state_t;

    state_t st_r;
    state_t st_nxt;
    logic activate_cmd;
    logic goto_cmd;
    logic auto_release_cmd;
    logic release_direction;
    logic [7:0] target_position_value;
    logic [7:0] speed_value;
    logic [7:0] force_value;
    logic [3:0] fault_code;
    logic rel_dir_r;
    logic stopped_r;
    logic [1:0] obj_r;
    logic [7:0] start_pos_r;
    logic [7:0] moved;
    logic blank;
    logic cal_s;
    logic lim_s;
    logic tgt_s;
    logic ovc_s;
    logic [7:0] pos_s;
    logic [7:0] stat0;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    grip_sync #(.W(12)) u_sync (
        .ref_clk(REF_CLK),
        .reset(RESET),
        .d({CAL_DONE, LIMIT_REACHED, AT_TARGET, OVER_CURRENT, FINGER_POS}),
        .q({cal_s, lim_s, tgt_s, ovc_s, pos_s})
    );

    // ****************************************
    // Command image writes
    // ****************************************
    // reserved bits dropped
    always_ff @(posedge REF_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            activate_cmd <= 1'b0;
            goto_cmd <= 1'b0;
            auto_release_cmd <= 1'b0;
            release_direction <= 1'b0;
        end
        else if (WR_EN && WR_ADDR == grip_cmd_pkg::OFS_ACTION)
        begin
            activate_cmd <= WR_DATA[grip_cmd_pkg::BIT_ACT];
            goto_cmd <= WR_DATA[grip_cmd_pkg::BIT_GOTO];
            auto_release_cmd <= WR_DATA[grip_cmd_pkg::BIT_ATR];
            release_direction <= WR_DATA[grip_cmd_pkg::BIT_DIR];
        end
    end

    always_ff @(posedge REF_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            target_position_value <= grip_cmd_pkg::RST_BYTE;
            speed_value <= grip_cmd_pkg::RST_BYTE;
            force_value <= grip_cmd_pkg::RST_BYTE;
        end
        else if (WR_EN)
        begin
            case (WR_ADDR)
                grip_cmd_pkg::OFS_TARGET: target_position_value <= WR_DATA;
                grip_cmd_pkg::OFS_SPEED: speed_value <= WR_DATA;
                grip_cmd_pkg::OFS_FORCE: force_value <= WR_DATA;
                default: ;
            endcase
        end
    end

    // ****************************************
    // Command sequencer
    // ****************************************
    always_comb
    begin
        st_nxt = st_r;
        case (st_r)
            ST_RESET:
                if (activate_cmd)
                    st_nxt = ST_CALIB;
            ST_CALIB:
                if (cal_s)
                    st_nxt = ST_IDLE;
            ST_IDLE:
                if (auto_release_cmd)
                    st_nxt = ST_RELEASE;
                else if (goto_cmd)
                    st_nxt = ST_MOVE;
            ST_MOVE:
                if (auto_release_cmd)
                    st_nxt = ST_RELEASE;
                else if (!goto_cmd)
                    st_nxt = ST_IDLE;
            ST_RELEASE:
                if (lim_s)
                    st_nxt = ST_LOCKED;
            ST_LOCKED:
                st_nxt = ST_LOCKED;
            default:
                st_nxt = ST_RESET;
        endcase
        if (!activate_cmd)
            st_nxt = ST_RESET;
    end

    always_ff @(posedge REF_CLK or posedge RESET)
    begin
        if (RESET)
            st_r <= ST_RESET;
        else
            st_r <= st_nxt;
    end

    always_ff @(posedge REF_CLK or posedge RESET)
    begin
        if (RESET)
            rel_dir_r <= 1'b0;
        else if (st_r != ST_RELEASE && st_nxt == ST_RELEASE)
            rel_dir_r <= release_direction;
    end

    // ****************************************
    // Move tracking and object detection
    // ****************************************
    assign moved = (pos_s >= start_pos_r) ? pos_s - start_pos_r : start_pos_r - pos_s;
    assign blank = moved < grip_cmd_pkg::BLANK_DIST;

    always_ff @(posedge REF_CLK or posedge RESET)
    begin
        if (RESET)
            start_pos_r <= grip_cmd_pkg::RST_BYTE;
        else if (st_r != ST_MOVE && st_nxt == ST_MOVE)
            start_pos_r <= pos_s;
    end

    always_ff @(posedge REF_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            stopped_r <= 1'b0;
            obj_r <= grip_cmd_pkg::OBJ_MOVING;
        end
        else if (st_r != ST_MOVE)
        begin
            stopped_r <= 1'b0;
            obj_r <= grip_cmd_pkg::OBJ_MOVING;
        end
        else if (!stopped_r && tgt_s)
        begin
            stopped_r <= 1'b1;
            obj_r <= grip_cmd_pkg::OBJ_AT_POS;
        end
        else if (!stopped_r && ovc_s && CURRENT_LIMIT_EN)
        begin
            stopped_r <= 1'b1;
            obj_r <= MOTOR_CLOSE ? grip_cmd_pkg::OBJ_CLOSING : grip_cmd_pkg::OBJ_OPENING;
        end
    end

    // ****************************************
    // Motor drive outputs
    // ****************************************
    // run toward target on goto
    // motion only in move or release
    always_ff @(posedge REF_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            MOTOR_RUN <= 1'b0;
            MOTOR_CLOSE <= 1'b0;
            CALIBRATE <= 1'b0;
        end
        else
        begin
            CALIBRATE <= st_r == ST_CALIB;
            MOTOR_RUN <= (st_r == ST_MOVE && goto_cmd && !stopped_r) || st_r == ST_RELEASE;
            if (st_r == ST_RELEASE)
                MOTOR_CLOSE <= !rel_dir_r;
            else
                MOTOR_CLOSE <= target_position_value > pos_s;
        end
    end

    // Release creeps at minimum speed, whatever was requested
    // speed follows register live
    always_ff @(posedge REF_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            MOTOR_SPEED <= grip_cmd_pkg::RST_BYTE;
            MOTOR_TARGET <= grip_cmd_pkg::RST_BYTE;
            CURRENT_LIMIT <= grip_cmd_pkg::RST_BYTE;
            CURRENT_LIMIT_EN <= 1'b0;
        end
        else
        begin
            MOTOR_SPEED <= (st_r == ST_RELEASE) ? grip_cmd_pkg::RST_BYTE : speed_value;
            MOTOR_TARGET <= target_position_value;
            CURRENT_LIMIT <= force_value;
            CURRENT_LIMIT_EN <= st_r == ST_MOVE && !blank;
        end
    end

    // ****************************************
    // Fault status
    // ****************************************
    // request while inactive
    always_ff @(posedge REF_CLK or posedge RESET)
    begin
        if (RESET)
            fault_code <= grip_cmd_pkg::FLT_NONE;
        else if (!activate_cmd)
            fault_code <= (goto_cmd || auto_release_cmd) ? grip_cmd_pkg::FLT_NO_ACT : grip_cmd_pkg::FLT_NONE;
        else if (st_r == ST_LOCKED || (st_r == ST_RELEASE && lim_s))
            fault_code <= grip_cmd_pkg::FLT_REL_DONE;
        else if (st_r == ST_RELEASE)
            fault_code <= grip_cmd_pkg::FLT_REL_BUSY;
        else if (fault_code == grip_cmd_pkg::FLT_NO_ACT)
            fault_code <= grip_cmd_pkg::FLT_NONE;
    end

    // ****************************************
    // Status image readback
    // ****************************************
    // activate and goto echoes
    always_comb
    begin
        stat0 = 8'h00;
        stat0[grip_cmd_pkg::BIT_ACT_ECHO] = activate_cmd;
        stat0[grip_cmd_pkg::BIT_GOTO_ECHO] = goto_cmd && st_r == ST_MOVE;
        stat0[grip_cmd_pkg::LSB_MOTION +: 2] = (st_r == ST_CALIB) ? grip_cmd_pkg::MOT_CALIB
            : (st_r == ST_IDLE || st_r == ST_MOVE) ? grip_cmd_pkg::MOT_READY : grip_cmd_pkg::MOT_RESET;
        stat0[grip_cmd_pkg::LSB_OBJECT +: 2] = obj_r;
    end

    always_ff @(posedge REF_CLK or posedge RESET)
    begin
        if (RESET)
            RD_DATA <= 8'h00;
        else
        begin
            case (RD_ADDR)
                grip_cmd_pkg::OFS_GRIP_STAT: RD_DATA <= stat0;
                grip_cmd_pkg::OFS_FAULT: RD_DATA <= {4'h0, fault_code};
                grip_cmd_pkg::OFS_POS_ECHO: RD_DATA <= target_position_value;
                grip_cmd_pkg::OFS_POSITION: RD_DATA <= pos_s;
                default: RD_DATA <= 8'h00;
            endcase
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (RESET);

    chk_deact_reset: assert property (
        !activate_cmd |=> st_r == ST_RESET)
        else $error("Sequencer not reset while inactive");
    chk_calib_start: assert property (
        (st_r == ST_RESET && activate_cmd) |=> st_r == ST_CALIB ##1 CALIBRATE)
        else $error("Calibration did not start");
    chk_run_goto: assert property (
        (MOTOR_RUN && $past(st_r) == ST_MOVE) |-> $past(goto_cmd))
        else $error("Motor ran without goto");
    chk_rel_prio: assert property (
        (st_r == ST_IDLE && activate_cmd && auto_release_cmd) |=> st_r == ST_RELEASE)
        else $error("Release did not override");
    chk_rel_dir: assert property (
        (st_r == ST_RELEASE && $past(st_r) == ST_RELEASE) |-> $stable(rel_dir_r))
        else $error("Release direction changed mid release");
    chk_fault_noact: assert property (
        (!activate_cmd && (goto_cmd || auto_release_cmd)) |=> fault_code == grip_cmd_pkg::FLT_NO_ACT)
        else $error("Missing inactive fault");
    chk_fault_rel: assert property (
        (st_r == ST_RELEASE && activate_cmd && lim_s) |=> fault_code == grip_cmd_pkg::FLT_REL_DONE ##1 !MOTOR_RUN)
        else $error("Release completion not faulted");
    chk_target_echo: assert property (
        (WR_EN && WR_ADDR == grip_cmd_pkg::OFS_TARGET && RD_ADDR == grip_cmd_pkg::OFS_POS_ECHO)
        ##1 (RD_ADDR == grip_cmd_pkg::OFS_POS_ECHO) |=> RD_DATA == $past(WR_DATA, 2))
        else $error("Target echo wrong");
    chk_blank_limit: assert property (
        (st_r == ST_MOVE && blank) |=> !CURRENT_LIMIT_EN)
        else $error("Force limit active inside blank distance");
    chk_speed_nostart: assert property (
        (WR_EN && WR_ADDR == grip_cmd_pkg::OFS_SPEED && st_r == ST_IDLE && !goto_cmd && !auto_release_cmd
         && activate_cmd) |=> st_r == ST_IDLE ##1 !MOTOR_RUN)
        else $error("Speed write started motion");

    cov_activate: cover property (st_r == ST_CALIB ##[1:1000] st_r == ST_IDLE);
    cov_move_obj: cover property (st_r == ST_MOVE && obj_r == grip_cmd_pkg::OBJ_CLOSING);
    cov_release: cover property (st_r == ST_RELEASE ##[1:1000] st_r == ST_LOCKED);

endmodule // grip_cmd

// >>> verif/grip_mech_model.sv
`timescale 1ns/10ps

module grip_mech_model #(
    parameter int CAL_CYC = 20,
    parameter int STEP_CYC = 6
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic calibrate,
    input wire logic motor_run,
    input wire logic motor_close,
    input wire logic [7:0] motor_target,
    input wire logic over_req,
    output logic cal_done,
    output logic limit_reached,
    output logic at_target,
    output logic over_current,
    output logic [7:0] finger_pos
);
    int cal_cnt_r;
    int step_r;
    logic [7:0] pos_r;

    // ****************************************
    // Calibration against the end stops
    // ****************************************
    // calibration run
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset || !calibrate)
            cal_cnt_r <= 0;
        else if (cal_cnt_r < CAL_CYC)
            cal_cnt_r <= cal_cnt_r + 1;
    end
    assign cal_done = calibrate && (cal_cnt_r == CAL_CYC);

    // ****************************************
    // Finger travel, one count per step
    // ****************************************
    // Step slower than the stop path, so fingers halt on target
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            step_r <= 0;
        else if (step_r == STEP_CYC - 1)
            step_r <= 0;
        else
            step_r <= step_r + 1;
    end

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset || calibrate)
            pos_r <= 8'h00;
        else if (step_r == STEP_CYC - 1 && motor_run && motor_close && pos_r != 8'hFF)
            pos_r <= pos_r + 8'h01;
        else if (step_r == STEP_CYC - 1 && motor_run && !motor_close && pos_r != 8'h00)
            pos_r <= pos_r - 8'h01;
    end
    assign finger_pos = pos_r;
    assign at_target = (pos_r == motor_target);
    assign limit_reached = motor_run && (motor_close ? pos_r == 8'hFF : pos_r == 8'h00);
    // Contact only when a scenario asks for it
    assign over_current = over_req;
endmodule // grip_mech_model

// >>> verif/grip_cmd_test.sv
`timescale 1ns/10ps

module grip_cmd_test;
    logic ref_clk, reset, wr_en, over_req, cal_done, limit_reached, at_target, over_current;
    logic calibrate, motor_run, motor_close, current_limit_en;
    logic [3:0] wr_addr, rd_addr;
    logic [7:0] wr_data, rd_data, finger_pos, motor_target, motor_speed, current_limit, rd;
    int mismatches = 0;
    int n_compared = 0;

    grip_cmd i_dut (.REF_CLK(ref_clk), .RESET(reset), .WR_EN(wr_en), .WR_ADDR(wr_addr), .WR_DATA(wr_data),
        .RD_ADDR(rd_addr), .RD_DATA(rd_data), .CAL_DONE(cal_done), .LIMIT_REACHED(limit_reached),
        .AT_TARGET(at_target), .OVER_CURRENT(over_current), .FINGER_POS(finger_pos), .CALIBRATE(calibrate),
        .MOTOR_RUN(motor_run), .MOTOR_CLOSE(motor_close), .MOTOR_TARGET(motor_target),
        .MOTOR_SPEED(motor_speed), .CURRENT_LIMIT(current_limit), .CURRENT_LIMIT_EN(current_limit_en));

    grip_mech_model i_mech (.ref_clk(ref_clk), .reset(reset), .calibrate(calibrate), .motor_run(motor_run),
        .motor_close(motor_close), .motor_target(motor_target), .over_req(over_req), .cal_done(cal_done),
        .limit_reached(limit_reached), .at_target(at_target), .over_current(over_current),
        .finger_pos(finger_pos));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic conclude;
        if (mismatches == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        wr_en = 1'b1;
        wr_addr = a;
        wr_data = d;
        @(posedge ref_clk);
        #1;
        wr_en = 1'b0;
    endtask

    // Status is registered, so one full cycle after the address
    task automatic rd_byte(input logic [3:0] a);
        @(posedge ref_clk);
        #1;
        rd_addr = a;
        @(posedge ref_clk);
        #1;
        rd = rd_data;
    endtask

    task automatic wait_run(input logic v, input int n);
        for (int i = 0; i < n && motor_run !== v; i++)
        begin
            @(posedge ref_clk);
            #1;
        end
        chk8("motor_run", {7'h00, v}, {7'h00, motor_run});
    endtask

    task automatic poll(input logic [3:0] a, input logic [7:0] mask, input logic [7:0] exp, input int n);
        for (int i = 0; i < n; i++)
        begin
            rd_byte(a);
            if ((rd & mask) === exp)
                break;
        end
        chk8("status", exp, rd & mask);
    endtask

    task automatic activate(input logic [7:0] act);
        wr(4'h0, act);
        for (int i = 0; i < 10 && calibrate !== 1'b1; i++)
        begin
            @(posedge ref_clk);
            #1;
        end
        chk8("calibrate", 8'h01, {7'h00, calibrate});
        poll(4'h0, 8'h3F, 8'h31, 60);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset;
        for (int a = 0; a < 6; a++)
        begin
            rd_byte(a[3:0]);
            chk8("reset status", 8'h00, rd);
        end
        for (int a = 6; a < 16; a++)
            wr(a[3:0], 8'h00);
    endtask

    task automatic t_no_act;
        wr(4'h0, 8'h08);
        repeat (6) @(posedge ref_clk);
        chk8("motor_run", 8'h00, {7'h00, motor_run});
        rd_byte(4'h2);
        chk8("fault", {4'h0, grip_cmd_pkg::FLT_NO_ACT}, rd);
        wr(4'h0, 8'h00);
        rd_byte(4'h2);
        chk8("fault", 8'h00, rd);
    endtask

    task automatic t_goto;
        activate(8'hC7);
        rd_byte(4'h1);
        chk8("reserved byte", 8'h00, rd);
        wr(4'h3, 8'h40);
        wr(4'h4, 8'h80);
        wr(4'h5, 8'h20);
        repeat (6) @(posedge ref_clk);
        chk8("motor_run", 8'h00, {7'h00, motor_run});
        chk8("current_limit", 8'h20, current_limit);
        rd_byte(4'h3);
        chk8("target echo", 8'h40, rd);
        wr(4'h0, 8'h09);
        wait_run(1'b1, 10);
        chk8("motor_target", 8'h40, motor_target);
        chk8("motor_close", 8'h01, {7'h00, motor_close});
        chk8("limit armed", 8'h00, {7'h00, current_limit_en});
        chk8("motor_speed", 8'h80, motor_speed);
        rd_byte(4'h0);
        chk8("goto echo", 8'h08, rd & 8'h08);
        wait_run(1'b0, 600);
        poll(4'h0, 8'hC0, 8'hC0, 10);
        rd_byte(4'h4);
        chk8("position", 8'h40, rd);
        rd_byte(4'h3);
        wr(4'h3, 8'h80);
        rd_byte(4'h3);
        chk8("target echo", 8'h80, rd);
        wr(4'h4, 8'h30);
        repeat (6) @(posedge ref_clk);
        chk8("motor_run", 8'h00, {7'h00, motor_run});
        chk8("motor_speed", 8'h30, motor_speed);
    endtask

    task automatic t_force_abort;
        wr(4'h0, 8'h01);
        wr(4'h0, 8'h09);
        wait_run(1'b1, 10);
        for (int i = 0; i < 80 && current_limit_en !== 1'b1; i++)
        begin
            @(posedge ref_clk);
            #1;
        end
        chk8("limit armed", 8'h01, {7'h00, current_limit_en});
        over_req = 1'b1;
        wait_run(1'b0, 10);
        poll(4'h0, 8'hC0, 8'h80, 10);
        over_req = 1'b0;
        wr(4'h0, 8'h01);
        wr(4'h3, 8'h20);
        wr(4'h0, 8'h09);
        wait_run(1'b1, 10);
        wr(4'h0, 8'h01);
        wait_run(1'b0, 6);
        wr(4'h0, 8'h09);
        wait_run(1'b1, 10);
        wr(4'h0, 8'h00);
        wait_run(1'b0, 4);
        rd_byte(4'h0);
        chk8("status0", 8'h00, rd & 8'h3F);
    endtask

    task automatic t_release;
        for (int d = 0; d < 2; d++)
        begin
            activate(8'h01);
            wr(4'h0, d ? 8'h39 : 8'h19);
            wait_run(1'b1, 10);
            chk8("motor_close", {7'h00, d == 0}, {7'h00, motor_close});
            chk8("motor_speed", 8'h00, motor_speed);
            poll(4'h2, 8'h0F, {4'h0, grip_cmd_pkg::FLT_REL_BUSY}, 4);
            poll(4'h2, 8'h0F, {4'h0, grip_cmd_pkg::FLT_REL_DONE}, 1000);
            chk8("motor_run", 8'h00, {7'h00, motor_run});
            wr(4'h0, 8'h01);
            wr(4'h0, 8'h09);
            repeat (6) @(posedge ref_clk);
            chk8("motor_run", 8'h00, {7'h00, motor_run});
            wr(4'h0, 8'h00);
            poll(4'h2, 8'hFF, 8'h00, 4);
        end
    endtask

    // ****************************************
    // Clock, reset, sequence, watchdog
    // ****************************************
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    initial
    begin
        reset = 1'b1;
        wr_en = 1'b0;
        wr_addr = 4'h0;
        wr_data = 8'h00;
        rd_addr = 4'h0;
        over_req = 1'b0;
        repeat (20) @(posedge ref_clk);
        #1;
        reset = 1'b0;
        t_reset();
        t_no_act();
        t_goto();
        t_force_abort();
        t_release();
        conclude();
    end

    // Whole run needs well under ten thousand cycles
    initial
    begin
        repeat (50000) @(posedge ref_clk);
        mismatches++;
        conclude();
    end
endmodule // grip_cmd_test
